//--- dv/lerc_user_model.sv
// user logic in the array: launches cell inputs and global pin levels
`timescale 1ns/10ps
`default_nettype none
module lerc_user_model
  import lerc_pkg::*;
(
  input wire logic clock,
  input wire lerc_cell_in_t [7:0] want_cell,
  input wire logic [3:0] want_glb,
  input wire logic [3:0] glb_inner,
  output lerc_cell_in_t [7:0] cell_in,
  output logic [3:0] global_pin
);
  // launched on the edge like any register in the array; a pin whose
  // line is driven from inside is grounded rather than left floating
  always_ff @(posedge clock) begin
    cell_in <= want_cell;
    global_pin <= want_glb & ~glb_inner;
  end
endmodule : lerc_user_model
`default_nettype wire

//--- dv/tb.sv
// self-checking bench for the logic block group
`timescale 1ns/10ps
`default_nettype none
`include "lerc_defines.svh"
module tb
  import lerc_pkg::*;
;
  logic clock, sys_rst, ram_we, chip_oe_n, chip_rst_n, carry_out, wb_ack_o;
  lerc_wb_req_t wb_req;
  logic [31:0] wb_dat_o, rd;
  logic [1:0] clk_pin, io_in;
  logic [3:0] global_pin, want_glb, glb_inner;
  lerc_cell_in_t [7:0] cell_in, want_cell;
  logic [7:0] cell_row, io_out, io_oe, ram_wdata, ram_rdata;
  logic [10:0] ram_addr;
  logic [15:0] lut [8];
  int mem [int];
  int mismatches, num_checks;

  lerc_top lerc_top_i (.clock(clock), .sys_rst(sys_rst), .wb_req(wb_req),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .clk_pin(clk_pin),
    .global_pin(global_pin), .io_in(io_in), .chip_oe_n(chip_oe_n),
    .chip_rst_n(chip_rst_n), .cell_in(cell_in), .cell_row(cell_row),
    .carry_out(carry_out), .io_out(io_out), .io_oe(io_oe),
    .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_we(ram_we),
    .ram_rdata(ram_rdata));
  lerc_user_model lerc_user_model_i (.clock(clock), .want_cell(want_cell),
    .want_glb(want_glb), .glb_inner(glb_inner), .cell_in(cell_in),
    .global_pin(global_pin));

  // free-running system clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask : idle

  // one classic cycle; the bounded wait guards against a missing ack
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    @(posedge clock);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) mismatches++;
    rd = wb_dat_o;
    wb_req <= '0;
  endtask : wb

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test

  // watchdog: the sequence needs well under a tenth of this span
  initial begin
    #200000;
    mismatches++;
    end_of_test();
  end

  // main sequence
  initial begin
    logic eb;
    int a;
    logic [7:0] wd;
    wb_req = '0;
    glb_inner = '0;
    sys_rst = 1'b1;
    ram_we = 1'b0;
    ram_addr = '0;
    ram_wdata = '0;
    clk_pin = '0;
    io_in = '0;
    chip_oe_n = 1'b1;
    chip_rst_n = 1'b1;
    want_glb = '0;
    want_cell = '0;
    mismatches = 0;
    num_checks = 0;
    void'($urandom(15557));
    idle(12);
    sys_rst <= 1'b0;
    check("oe_reset", io_oe, 8'hFF);
    // configuration words come up cleared; a hole reads zero
    for (int r = 0; r < 8; r++) begin
      wb(1'b0, 8'(4 * r), 32'h0000_0000);
      check("cfg_reset", rd, `LERC_CFG_RST);
    end
    wb(1'b1, 8'h30, 32'hFFFF_FFFF);
    wb(1'b0, 8'h30, 32'h0000_0000);
    check("hole", rd, 32'h0000_0000);
    // bypassed cells: any function of four inputs
    wb(1'b1, `LERC_ADR_CELL, 32'h0000_FF00);
    for (int w = 0; w < 4; w++) begin
      lut[2 * w] = 16'($urandom);
      lut[2 * w + 1] = 16'($urandom);
      wb(1'b1, 8'(`LERC_ADR_LUT + 4 * w), {lut[2 * w + 1], lut[2 * w]});
    end
    repeat (24) begin
      io_in <= 2'($urandom);
      for (int c = 0; c < 8; c++) want_cell[c] <= '{1'b0, 4'($urandom)};
      idle(4);
      for (int c = 0; c < 8; c++) begin
        check("lut", cell_row[c], lut[c][want_cell[c].d]);
      end
    end
    // both controls from global lines held high; clear wins on the reg
    wb(1'b1, `LERC_ADR_CELL, 32'h0000_0000);
    wb(1'b1, `LERC_ADR_SRC, 32'h0000_0050);
    want_glb <= 4'hF;
    for (int m = 1; m < 7; m++) begin
      for (int v = 0; v < 2; v++) begin
        for (int c = 0; c < 8; c++) want_cell[c].d[3] <= v[0];
        wb(1'b1, `LERC_ADR_CELL, 32'(m));
        idle(8);
        eb = (m == 6) ? v[0] : (m < 3 || m == 5);
        for (int c = 0; c < 8; c++) begin
          check("async", cell_row[c], eb);
        end
      end
    end
    // registered cells: clock from a pin, enable gates the capture
    want_glb <= 4'h0;
    idle(8);
    wb(1'b1, `LERC_ADR_CELL, 32'h0000_0000);
    for (int c = 0; c < 8; c++) want_cell[c] <= '{1'b0, 4'($urandom)};
    for (int e = 0; e < 2; e++) begin
      for (int c = 0; c < 8; c++) want_cell[c].ena <= e[0];
      idle(2);
      clk_pin <= 2'b01;
      idle(8);
      clk_pin <= 2'b00;
      idle(8);
      for (int c = 0; c < 8; c++) begin
        eb = e ? lut[c][want_cell[c].d] : 1'b1;
        check("reg", cell_row[c], eb);
      end
    end
    // arithmetic cells: two bytes ripple-added, top carry leaves the group
    wb(1'b1, `LERC_ADR_CELL, 32'h00FF_FF00);
    repeat (8) begin
      for (int c = 0; c < 8; c++) want_cell[c] <= '{1'b0, 4'($urandom)};
      idle(4);
      a = 0;
      for (int c = 0; c < 8; c++) begin
        a += (int'(want_cell[c].d[0]) + int'(want_cell[c].d[1])) << c;
      end
      check("sum", cell_row, a[7:0]);
      check("carry", carry_out, a[8]);
    end
    // global lines driven from cells; the model grounds their pins
    glb_inner <= 4'hF;
    wb(1'b1, `LERC_ADR_GLB, 32'h0000_000F);
    wb(1'b0, `LERC_ADR_STAT, 32'h0000_0000);
    check("glb_int", rd[12:9], a[3:0]);
    check("status_row", rd[8:0], a[8:0]);
    glb_inner <= 4'h0;
    // chip-wide output enable and io reset
    wb(1'b1, `LERC_ADR_GLB, 32'h0000_0010);
    chip_oe_n <= 1'b0;
    idle(8);
    check("oe_low", io_oe, 8'h00);
    chip_oe_n <= 1'b1;
    idle(8);
    check("oe_high", io_oe, 8'hFF);
    // outputs pick input row channels; select 12 is refused and gives 0
    wb(1'b1, `LERC_ADR_IOSEL, 32'hCBA9_8BA8);
    for (int v = 1; v < 4; v++) begin
      io_in <= 2'(v);
      idle(8);
      check("io_mux", io_out, {1'b0, v[1], v[0], v[1], v[0], v[1], v[0], v[0]});
    end
    chip_rst_n <= 1'b0;
    idle(8);
    check("io_rst", io_out, 8'h00);
    chip_rst_n <= 1'b1;
    // ram in each shape; unused data bits read zero
    for (int s = 0; s < 4; s++) begin
      wb(1'b1, `LERC_ADR_GLB, 32'(s) << 5);
      mem.delete();
      repeat (16) begin
        a = $urandom % (256 << s);
        @(posedge clock);
        ram_we <= 1'b1;
        ram_addr <= a[10:0];
        wd = 8'($urandom);
        ram_wdata <= wd;
        mem[a] = wd & ((1 << (8 >> s)) - 1);
      end
      @(posedge clock);
      ram_we <= 1'b0;
      foreach (mem[k]) begin
        @(posedge clock);
        ram_addr <= k[10:0];
        idle(2);
        check("ram", ram_rdata, mem[k]);
      end
    end
    // pattern loaded at configuration holds against user writes
    wb(1'b1, `LERC_ADR_GLB, 32'h0000_0000);
    wb(1'b1, `LERC_ADR_RAMLD, 32'h0005_00A5);
    wb(1'b1, `LERC_ADR_GLB, 32'h0000_0080);
    @(posedge clock);
    ram_we <= 1'b1;
    ram_addr <= 11'h005;
    ram_wdata <= 8'h5A;
    @(posedge clock);
    ram_we <= 1'b0;
    idle(2);
    check("rom", ram_rdata, 8'hA5);
    end_of_test();
  end
endmodule : tb
`default_nettype wire

//--- src/lerc_defines.svh
// offsets, field positions, reset values and sizes of the logic group model
// Notes on behaviour
// - four shared invertible controls reach eight cells
// - two controls clock, two clear or preset
// - clocks may use pins; clear/preset may not
// - each cell has a four-input lookup table
// - cell register has enable; output reaches routing
// - carry ripples upward; last carry is general
// - adder register bypassed or used as accumulator (here the adder sums cell inputs d[0] and d[1] only, never q)
// - third input high: first control presets
// - single-control preset frees the third input
// - preset-and-clear: first presets, second clears
// - load-with-clear: first loads, second clears
// - load-with-preset: inverted register, second presets
// - plain load: first control loads third input
// - global lines driven by pins or cells
// - chip output enable low floats all outputs
// - chip reset low clears io cell registers
// - inputs feed two row channels; outputs multiplex
// - ram write strobe self-timed from clock
// - ram sizes 256x8, 512x4, 1024x2, 2048x1
// - ram may hold a fixed read-only pattern
`ifndef LERC_DEFINES_SVH
`define LERC_DEFINES_SVH
`define LERC_ADR_SRC 8'h00
`define LERC_ADR_CELL 8'h04
`define LERC_ADR_GLB 8'h08
`define LERC_ADR_IOSEL 8'h0C
`define LERC_ADR_LUT 8'h10
`define LERC_ADR_STAT 8'h20
`define LERC_ADR_RAMLD 8'h24
`define LERC_SRC_INV_LSB 8
`define LERC_CELL_BYP_LSB 8
`define LERC_CELL_ARITH_LSB 16
`define LERC_CELL_CKSEL_LSB 24
`define LERC_GLB_OE_BIT 4
`define LERC_GLB_SIZE_LSB 5
`define LERC_GLB_ROM_BIT 7
`define LERC_RAMLD_ADR_LSB 16
`define LERC_CFG_RST 32'h0000_0000
`define LERC_SYNC_RST 10'h300
`define LERC_CELLS 8
`define LERC_CFG_WORDS 8
`define LERC_RAM_BITS 2048
`define LERC_ROW_CH 12
`endif

//--- src/lerc_pkg.sv
// types shared by the logic group model
package lerc_pkg;
  // asynchronous register modes, shared by all cells of the group
  typedef enum logic [2:0] {
    LERC_AM_OFF = 3'h0,
    LERC_AM_PRE_LOAD = 3'h1,
    LERC_AM_PRE_INV = 3'h2,
    LERC_AM_PRE_CLR = 3'h3,
    LERC_AM_LOAD_CLR = 3'h4,
    LERC_AM_LOAD_PRE = 3'h5,
    LERC_AM_LOAD = 3'h6
  } lerc_amode_t;
  // source of a group control
  typedef enum logic [1:0] {
    LERC_SRC_PIN = 2'h0,
    LERC_SRC_GLOBAL = 2'h1,
    LERC_SRC_IO = 2'h2,
    LERC_SRC_LOCAL = 2'h3
  } lerc_src_t;
  // classic wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } lerc_wb_req_t;
  // user-side inputs of one logic cell
  typedef struct packed {
    logic ena;
    logic [3:0] d;
  } lerc_cell_in_t;
endpackage : lerc_pkg

//--- src/lerc_top.sv
// one logic block group: eight cells, io cells, ram block, wishbone regs
`timescale 1ns/10ps
`default_nettype none
`include "lerc_defines.svh"
module lerc_top
  import lerc_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire lerc_wb_req_t wb_req,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [1:0] clk_pin,
  input wire logic [3:0] global_pin,
  input wire logic [1:0] io_in,
  input wire logic chip_oe_n,
  input wire logic chip_rst_n,
  input wire lerc_cell_in_t [7:0] cell_in,
  output logic [7:0] cell_row,
  output logic carry_out,
  output logic [7:0] io_out,
  output logic [7:0] io_oe,
  input wire logic [10:0] ram_addr,
  input wire logic [7:0] ram_wdata,
  input wire logic ram_we,
  output logic [7:0] ram_rdata
);

  // byte-lane merge for register writes
  function automatic logic [31:0] wb_merge(input logic [31:0] old,
                                           input logic [31:0] dat,
                                           input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = dat[8*b +: 8];
      end
    end
    return res;
  endfunction : wb_merge

  // pick a control source; pins are refused where not allowed
  function automatic logic ctl_pick(input logic [1:0] src,
                                    input logic pin_ok,
                                    input logic pin,
                                    input logic glob,
                                    input logic io,
                                    input logic loc);
    logic res;
    res = 1'b0;
    unique case (lerc_src_t'(src))
      LERC_SRC_PIN: res = pin_ok & pin;
      LERC_SRC_GLOBAL: res = glob;
      LERC_SRC_IO: res = io;
      LERC_SRC_LOCAL: res = loc;
    endcase
    return res;
  endfunction : ctl_pick

  // first bit of a ram word for the chosen size
  function automatic logic [10:0] ram_base(input logic [10:0] adr,
                                           input logic [1:0] size);
    logic [10:0] mask;
    mask = 11'(({3'h0, 8'hFF} << size) | {8'h00, 3'h7 >> (2'h3 - size)});
    return 11'((adr & (mask >> 0)) << (2'h3 - size)) & 11'h7FF;
  endfunction : ram_base

  // bits per ram word for the chosen size
  function automatic logic [3:0] ram_width(input logic [1:0] size);
    return 4'(4'h8 >> size);
  endfunction : ram_width

  // ---------------- wishbone slave ----------------
  logic [31:0] cfg [0:`LERC_CFG_WORDS-1];
  logic [31:0] status;
  logic [31:0] rd_val;
  logic [2:0] cfg_idx;
  logic req, wr_ok, cfg_hit, ld_hit;

  // writes land on the edge where ack is high, as the master samples it
  assign req = wb_req.cyc & wb_req.stb;
  assign wr_ok = req & wb_req.we & wb_ack_o;
  assign cfg_hit = wb_req.adr < `LERC_ADR_STAT;
  assign ld_hit = wb_req.adr[7:2] == `LERC_ADR_RAMLD >> 2;
  assign cfg_idx = wb_req.adr[4:2];
  assign rd_val = cfg_hit ? cfg[cfg_idx] :
                  (wb_req.adr[7:2] == `LERC_ADR_STAT >> 2) ? status :
                  32'h0000_0000;

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
      wb_dat_o <= (req & ~wb_ack_o) ? rd_val : 32'h0000_0000;
    end
  end

  // configuration words
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      for (int w = 0; w < `LERC_CFG_WORDS; w++) begin
        cfg[w] <= `LERC_CFG_RST;
      end
    end else if (wr_ok & cfg_hit) begin
      cfg[cfg_idx] <= wb_merge(cfg[cfg_idx], wb_req.dat, wb_req.sel);
    end
  end

  // configuration fields
  logic [7:0] src_f;
  logic [3:0] inv_f, glb_int;
  logic [7:0] bypass, arith, cksel;
  lerc_amode_t mode;
  logic oe_en, rom;
  logic [1:0] size;
  assign src_f = cfg[0][7:0];
  assign inv_f = cfg[0][`LERC_SRC_INV_LSB +: 4];
  assign mode = lerc_amode_t'(cfg[1][2:0]);
  assign bypass = cfg[1][`LERC_CELL_BYP_LSB +: 8];
  assign arith = cfg[1][`LERC_CELL_ARITH_LSB +: 8];
  assign cksel = cfg[1][`LERC_CELL_CKSEL_LSB +: 8];
  assign glb_int = cfg[2][3:0];
  assign oe_en = cfg[2][`LERC_GLB_OE_BIT];
  assign size = cfg[2][`LERC_GLB_SIZE_LSB +: 2];
  assign rom = cfg[2][`LERC_GLB_ROM_BIT];

  // ---------------- pin synchronisers ----------------
  // three stages; a change counts once stages two and three agree
  logic [9:0] pin_raw, s1, s2, s3, pin_f, next_pin_f, agree;
  assign pin_raw = {chip_rst_n, chip_oe_n, io_in, global_pin, clk_pin};
  assign agree = ~(s2 ^ s3);
  assign next_pin_f = (s3 & agree) | (pin_f & ~agree);
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      s1 <= `LERC_SYNC_RST;
      s2 <= `LERC_SYNC_RST;
      s3 <= `LERC_SYNC_RST;
      pin_f <= `LERC_SYNC_RST;
    end else begin
      s1 <= pin_raw;
      s2 <= s1;
      s3 <= s2;
      pin_f <= next_pin_f;
    end
  end
  logic [1:0] clk_pin_s, io_s;
  logic [3:0] glb_pin_s;
  logic oe_n_s, rst_n_s;
  assign clk_pin_s = pin_f[1:0];
  assign glb_pin_s = pin_f[5:2];
  assign io_s = pin_f[7:6];
  assign oe_n_s = pin_f[8];
  assign rst_n_s = pin_f[9];

  // ---------------- global lines and group controls ----------------
  // internal drive uses the registered cell output; the pin is then unused
  logic [3:0] glb_line, gc_raw, gc, gc_q;
  logic [1:0] ck_edge;
  logic ctl1, ctl2;
  assign glb_line = (glb_int & cell_row[3:0]) | (~glb_int & glb_pin_s);
  assign gc_raw[0] = ctl_pick(src_f[1:0], 1'b1, clk_pin_s[0], glb_line[0],
                              io_s[0], cell_row[0]);
  assign gc_raw[1] = ctl_pick(src_f[3:2], 1'b1, clk_pin_s[1], glb_line[1],
                              io_s[1], cell_row[1]);
  assign gc_raw[2] = ctl_pick(src_f[5:4], 1'b0, 1'b0, glb_line[2],
                              io_s[0], cell_row[2]);
  assign gc_raw[3] = ctl_pick(src_f[7:6], 1'b0, 1'b0, glb_line[3],
                              io_s[1], cell_row[3]);
  assign gc = gc_raw ^ inv_f;
  assign ck_edge = gc[1:0] & ~gc_q[1:0];
  assign ctl1 = gc[2];
  assign ctl2 = gc[3];

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      gc_q <= 4'h0;
    end else begin
      gc_q <= gc;
    end
  end

  // ---------------- logic cells ----------------
  logic [7:0] d0v, d1v, d3v, ena, lut_bit, sum, cin, cout, comb;
  logic [7:0] ldval, pre_i, clr_i, q, inner, regout, cell_val, cap, next_q;
  logic pre_ld, inv_out, ld_on, clr2_on, pre1_on, preinv_on;

  // lookup per cell; a preset by load holds the third lookup input high
  always_comb begin
    for (int i = 0; i < `LERC_CELLS; i++) begin
      d0v[i] = cell_in[i].d[0];
      d1v[i] = cell_in[i].d[1];
      d3v[i] = cell_in[i].d[3];
      ena[i] = cell_in[i].ena;
      lut_bit[i] = cfg[4 + i/2][16*(i%2) +
        int'({pre_ld | cell_in[i].d[3], cell_in[i].d[2:0]})];
    end
  end

  // ripple carry; the top carry leaves as a general signal
  assign cin = {cout[6:0], 1'b0};
  assign sum = d0v ^ d1v ^ cin;
  assign cout = (d0v & d1v) | (cin & (d0v ^ d1v));
  assign comb = (arith & sum) | (~arith & lut_bit);

  // mode decode, shared by the group
  assign pre_ld = mode == LERC_AM_PRE_LOAD;
  assign inv_out = (mode == LERC_AM_PRE_INV) | (mode == LERC_AM_LOAD_PRE);
  assign ld_on = ctl1 & ((mode == LERC_AM_PRE_LOAD) | (mode == LERC_AM_LOAD_CLR)
                 | (mode == LERC_AM_LOAD_PRE) | (mode == LERC_AM_LOAD));
  assign clr2_on = ctl2 & ((mode == LERC_AM_PRE_CLR)
                   | (mode == LERC_AM_LOAD_CLR) | (mode == LERC_AM_LOAD_PRE));
  assign pre1_on = ctl1 & (mode == LERC_AM_PRE_CLR);
  assign preinv_on = ctl1 & (mode == LERC_AM_PRE_INV);

  // a load steers both preset and clear from the value to load
  assign ldval = pre_ld ? 8'hFF :
                 (mode == LERC_AM_LOAD_PRE) ? ~d3v : d3v;
  assign pre_i = {8{pre1_on}} | ({8{ld_on}} & ldval);
  assign clr_i = {8{clr2_on | preinv_on}} | ({8{ld_on}} & ~ldval);
  // clear wins over preset so both asserted hold zero
  assign inner = ~clr_i & (pre_i | q);
  assign regout = inner ^ {8{inv_out}};
  assign cell_val = (bypass & comb) | (~bypass & regout);
  assign cap = ena & ((cksel & {8{ck_edge[1]}}) | (~cksel & {8{ck_edge[0]}}));
  assign next_q = ~clr_i & (pre_i | (cap & (comb ^ {8{inv_out}}))
                  | (~cap & q));

  // cell registers run on the system clock; group clocks act as edges
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      q <= 8'h00;
      cell_row <= 8'h00;
      carry_out <= 1'b0;
    end else begin
      q <= next_q;
      cell_row <= cell_val;
      carry_out <= cout[7];
    end
  end
  assign status = {15'h0000, gc, glb_line, carry_out, cell_row};

  // ---------------- io cells ----------------
  logic [11:0] row_ch;
  logic [7:0] io_next;
  // each input io cell drives two row channels
  assign row_ch = {io_s, io_s, cell_row};
  always_comb begin
    for (int o = 0; o < 8; o++) begin
      io_next[o] = (cfg[3][4*o +: 4] < 4'hC) ? row_ch[cfg[3][4*o +: 4]] : 1'b0;
    end
  end
  // chip reset is a pin, so it clears through the synchroniser
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      io_out <= 8'h00;
    end else begin
      io_out <= rst_n_s ? io_next : 8'h00;
    end
  end
  assign io_oe = {8{~(oe_en & ~oe_n_s)}};

  // ---------------- embedded ram block ----------------
  // storage is bit-wide so every size shares one array
  logic mem [0:`LERC_RAM_BITS-1];
  logic ld_wr, ram_wstb, any_wr;
  logic [10:0] wbase, rbase;
  logic [7:0] wbits, rbits;
  logic [3:0] width;
  assign width = ram_width(size);
  assign ld_wr = wr_ok & ld_hit;
  assign ram_wstb = ram_we & ~rom;
  assign any_wr = ld_wr | ram_wstb;
  assign rbase = ram_base(ram_addr, size);
  assign wbase = ld_wr ?
                 ram_base(wb_req.dat[`LERC_RAMLD_ADR_LSB +: 11], size) :
                 rbase;
  assign wbits = ld_wr ? wb_req.dat[7:0] : ram_wdata;
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      rbits[k] = (4'(k) < width) ? mem[11'(rbase + 11'(k))] : 1'b0;
    end
  end
  // write strobe is made here from the clock; user meets clock timing only
  always_ff @(posedge clock) begin
    for (int k = 0; k < 8; k++) begin
      if (any_wr && 4'(k) < width) begin
        mem[11'(wbase + 11'(k))] <= wbits[k];
      end
    end
  end
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ram_rdata <= 8'h00;
    end else begin
      ram_rdata <= rbits;
    end
  end

  // ---------------- assertions ----------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence ram_wr_s;
    ram_we && !rom && !ld_wr && size == 2'h0;
  endsequence
  sequence ram_hold_s;
    ram_addr == $past(ram_addr) && !ram_we && !ld_wr && size == 2'h0;
  endsequence

  clear_wins_a: assert property (
    clr_i[0] && pre_i[0] |=> q[0] == 1'b0 && inner[0] == 1'b0 || clr_i[0] == 1'b0)
    else $error("clear did not win over preset");
  preset_load_a: assert property (
    mode == LERC_AM_PRE_LOAD && ctl1 |-> regout[0] == 1'b1)
    else $error("preset by load missing");
  pre_clr_a: assert property (
    mode == LERC_AM_PRE_CLR && ctl2 |-> regout[1] == 1'b0)
    else $error("second control did not clear");
  load_clr_a: assert property (
    mode == LERC_AM_LOAD_CLR && ctl1 && !ctl2 |-> regout[2] == d3v[2])
    else $error("load did not follow third input");
  load_pre_a: assert property (
    mode == LERC_AM_LOAD_PRE && ctl2 |-> regout[3] == 1'b1)
    else $error("inverted preset missing");
  plain_load_a: assert property (
    mode == LERC_AM_LOAD && ctl1 |-> regout[4] == d3v[4])
    else $error("plain load wrong");
  carry_row_a: assert property (
    arith[0] && bypass[1] && arith[1] |=> cell_row[1] == $past(sum[1]))
    else $error("carry sum not routed");
  chip_oe_a: assert property (
    oe_en && !oe_n_s |-> io_oe == 8'h00)
    else $error("outputs not floated");
  io_reset_a: assert property (
    !rst_n_s |=> io_out == 8'h00)
    else $error("io registers not reset");
  ram_write_a: assert property (
    ram_wr_s ##1 ram_hold_s |=> ram_rdata == $past(ram_wdata, 2))
    else $error("ram write not read back");
  bus_ack_a: assert property (
    req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single cycle");

endmodule : lerc_top
`default_nettype wire
